// File: inc/sio3_pkg.sv
/*
 constants and carrier types for the three-wire clocked serial port.
 assumes a 50 MHz ref_clk; all timing counts derive from that rate.
*/
// Function
// [RULE_01] shift msb out on each clock fall
// [RULE_02] sample input into lsb on each rise
// [RULE_03] master: writing data starts the transfer
// [RULE_04] slave: clock pin released, wait for master
// [RULE_05] request flag set at eighth clock rise
// [RULE_06] master clock stops high after eighth rise
// [RULE_07] push-pull output from latch; flags force it
// [RULE_08] software leaves latch flags alone mid-transfer
// [RULE_09] both upper mode bits zero select three-wire
// [RULE_10] enabled with source one: internal clock, master
// [RULE_11] enabled with source zero: external clock, slave
// [RULE_12] software sets data pin output, latch zero
// [RULE_13] software sets clock pin output, latch one
// [RULE_14] written data starts at once, eight bits out
// [RULE_15] enable after write does not start transfer
// [RULE_16] software enables interrupts and permit flag
// [RULE_17] accepted request branches to serial vector
// [RULE_18] idle: shift register holds, counter stays zero
package sio3_pkg;
    localparam int SIO3_WIDTH = 8;
    localparam int SIO3_FIFO_DEPTH = 8;
    localparam int SIO3_CLK_PERIOD_NS = 20;
    // half period of the internally generated shift clock
    localparam int SIO3_SCK_HALF_NS = 400;
    localparam int SIO3_SCK_HALF_CYC =
        (SIO3_SCK_HALF_NS + SIO3_CLK_PERIOD_NS - 1) / SIO3_CLK_PERIOD_NS;
    localparam logic [3:0] SIO3_LAST_BIT = 4'h7;
    localparam logic [3:0] SIO3_CNT_RST = 4'h0;
    localparam logic [7:0] SIO3_SR_RST = 8'h00;
    localparam logic SIO3_SO_RST = 1'b1;
    localparam logic SIO3_SCK_IDLE = 1'b1;
    // arbitrary value, system integration sets the real vector
    localparam logic [7:0] SIO3_VECTOR = 8'h2A;

    typedef struct packed {
        logic serial_if_enable_flag;
        logic mode_select_bit2;
        logic mode_select_bit1;
        logic clock_source_select;
    } sio3_ctrl_t;

    typedef struct packed {
        logic bus_release_trigger_flag;
        logic command_trigger_flag;
    } sio3_trig_t;

    typedef enum logic [1:0] {
        SIO3_IDLE = 2'b00,
        SIO3_SHIFT = 2'b01
    } sio3_state_t;
endpackage : sio3_pkg

// File: src/sio3_top.sv
/*
 three-wire serial port: 8-word transmit fifo, 8-bit shifter, master clock
 generator, slave edge detection, sticky request flag.
 assumes pins arrive asynchronous to ref_clk; clock pin tristate resolved
 outside from serial_clock_pin_oe.
*/
module sio3_fifo
    import sio3_pkg::*;
#(
    parameter int WIDTH = SIO3_WIDTH,
    parameter int DEPTH = SIO3_FIFO_DEPTH
)
(
    // clock and control
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic flush,
    // fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam logic [AW:0] FULL = (AW + 1)'(DEPTH);
    localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_r;
    logic [AW-1:0] rd_r;
    logic [AW:0] cnt_r;
    logic [AW:0] cnt_nxt;
    logic push;
    logic pop;

    assign push = in_valid && in_ready && !flush;
    assign pop = out_valid && out_ready && !flush;
    assign out_data = mem[rd_r];

    always_comb
    begin
        cnt_nxt = cnt_r;
        if (flush)
        begin
            cnt_nxt = '0;
        end
        else if (push && !pop)
        begin
            cnt_nxt = cnt_r + 1'b1;
        end
        else if (pop && !push)
        begin
            cnt_nxt = cnt_r - 1'b1;
        end
    end

    always_ff @(posedge clk)
    begin
        if (ce && push)
        begin
            mem[wr_r] <= in_data;
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wr_r <= '0;
            rd_r <= '0;
        end
        else if (ce)
        begin
            if (flush)
            begin
                wr_r <= '0;
                rd_r <= '0;
            end
            else
            begin
                if (push)
                begin
                    wr_r <= (wr_r == LAST) ? '0 : wr_r + 1'b1;
                end
                if (pop)
                begin
                    rd_r <= (rd_r == LAST) ? '0 : rd_r + 1'b1;
                end
            end
        end
    end

    // flags registered so the top sees them straight from flops
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cnt_r <= '0;
            in_ready <= 1'b0;
            out_valid <= 1'b0;
        end
        else if (ce)
        begin
            cnt_r <= cnt_nxt;
            in_ready <= (cnt_nxt != FULL);
            out_valid <= (cnt_nxt != '0);
        end
    end
endmodule : sio3_fifo

module sio3_top
    import sio3_pkg::*;
#(
    parameter int SCK_HALF_CYC = SIO3_SCK_HALF_CYC,
    parameter int FIFO_DEPTH = SIO3_FIFO_DEPTH
)
(
    // clock, reset, enable
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic clk_en,
    // configuration and software flags
    input wire sio3_ctrl_t ctrl,
    input wire sio3_trig_t trig,
    input wire logic serial_irq_permit_flag,
    input wire logic global_interrupt_enable,
    input wire logic irq_accept,
    // transmit stream into the fifo
    input wire logic tx_valid,
    output logic tx_ready,
    input wire logic [SIO3_WIDTH-1:0] tx_data,
    // received byte and status
    output logic [SIO3_WIDTH-1:0] rx_data_r,
    output logic rx_valid_r,
    output logic busy_r,
    output logic serial_irq_request_flag,
    output logic cpu_irq_r,
    output logic [7:0] irq_vector_r,
    // pins
    input wire logic serial_clock_pin_i,
    output logic serial_clock_pin_o,
    output logic serial_clock_pin_oe,
    input wire logic serial_data_in_pin,
    output logic serial_data_out_pin
);
    localparam logic [7:0] HALF_LAST = 8'(SCK_HALF_CYC - 1);

    logic rst_s1_r;
    logic rst_n;
    logic sck_s1_r;
    logic sck_s2_r;
    logic sck_s3_r;
    logic si_s1_r;
    logic si_s2_r;
    sio3_state_t state_r;
    logic [SIO3_WIDTH-1:0] sr_r;
    logic [3:0] cnt_r;
    logic [7:0] div_r;
    logic three_wire;
    logic active;
    logic master;
    logic fall_ev;
    logic rise_ev;
    logic done_ev;
    logic start;
    logic fifo_valid;
    logic [SIO3_WIDTH-1:0] fifo_data;

    // reset released through two flops
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            rst_s1_r <= 1'b0;
            rst_n <= 1'b0;
        end
        else
        begin
            rst_s1_r <= 1'b1;
            rst_n <= rst_s1_r;
        end
    end

    // pin synchronisers; third clock flop only for edge detection
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sck_s1_r <= SIO3_SCK_IDLE;
            sck_s2_r <= SIO3_SCK_IDLE;
            sck_s3_r <= SIO3_SCK_IDLE;
            si_s1_r <= 1'b0;
            si_s2_r <= 1'b0;
        end
        else if (clk_en)
        begin
            sck_s1_r <= serial_clock_pin_i;
            sck_s2_r <= sck_s1_r;
            sck_s3_r <= sck_s2_r;
            si_s1_r <= serial_data_in_pin;
            si_s2_r <= si_s1_r;
        end
    end

    assign three_wire = !ctrl.mode_select_bit2 && !ctrl.mode_select_bit1; // [RULE_09]
    assign active = ctrl.serial_if_enable_flag && three_wire;
    assign master = ctrl.clock_source_select; // [RULE_10] [RULE_11]
    assign start = (state_r == SIO3_IDLE) && active && fifo_valid; // [RULE_03] [RULE_14]

    // master edges come from the divider, slave edges from the pin
    always_comb
    begin
        fall_ev = 1'b0;
        rise_ev = 1'b0;
        if (state_r == SIO3_SHIFT)
        begin
            if (master)
            begin
                fall_ev = (div_r == HALF_LAST) && serial_clock_pin_o;
                rise_ev = (div_r == HALF_LAST) && !serial_clock_pin_o;
            end
            else
            begin
                fall_ev = sck_s3_r && !sck_s2_r; // [RULE_04] [RULE_11]
                rise_ev = !sck_s3_r && sck_s2_r;
            end
        end
    end
    assign done_ev = rise_ev && (cnt_r == SIO3_LAST_BIT); // [RULE_05]

    // bytes written while disabled are flushed, so a late enable starts nothing
    sio3_fifo #(
        .WIDTH(SIO3_WIDTH),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk(ref_clk),
        .rst_n(rst_n),
        .ce(clk_en),
        .flush(!active), // [RULE_15]
        .in_valid(tx_valid),
        .in_ready(tx_ready),
        .in_data(tx_data),
        .out_valid(fifo_valid),
        .out_ready(start),
        .out_data(fifo_data)
    );

    // transfer sequencing and shifter
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_r <= SIO3_IDLE;
            sr_r <= SIO3_SR_RST;
            cnt_r <= SIO3_CNT_RST;
        end
        else if (clk_en)
        begin
            unique case (state_r)
                SIO3_IDLE:
                begin
                    cnt_r <= SIO3_CNT_RST; // [RULE_18]
                    if (start)
                    begin
                        sr_r <= fifo_data; // [RULE_03]
                        state_r <= SIO3_SHIFT;
                    end
                end
                SIO3_SHIFT:
                begin
                    if (!active)
                    begin
                        state_r <= SIO3_IDLE; // [RULE_18]
                        cnt_r <= SIO3_CNT_RST;
                    end
                    else if (rise_ev)
                    begin
                        sr_r <= {sr_r[SIO3_WIDTH-2:0], si_s2_r}; // [RULE_02]
                        cnt_r <= cnt_r + 4'h1;
                        if (done_ev)
                        begin
                            state_r <= SIO3_IDLE;
                            cnt_r <= SIO3_CNT_RST;
                        end
                    end
                end
            endcase
        end
    end

    // internal shift clock; parks high after the eighth rise
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            div_r <= 8'h00;
            serial_clock_pin_o <= SIO3_SCK_IDLE;
            serial_clock_pin_oe <= 1'b0;
        end
        else if (clk_en)
        begin
            serial_clock_pin_oe <= active && master; // [RULE_04] [RULE_10]
            if (state_r != SIO3_SHIFT || !master || !active)
            begin
                div_r <= 8'h00;
                serial_clock_pin_o <= SIO3_SCK_IDLE; // [RULE_06]
            end
            else if (div_r == HALF_LAST)
            begin
                div_r <= 8'h00;
                serial_clock_pin_o <= !serial_clock_pin_o;
            end
            else
            begin
                div_r <= div_r + 8'h01;
            end
        end
    end

    // output latch: shifter owns it mid-transfer, flags only when idle
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            serial_data_out_pin <= SIO3_SO_RST;
        end
        else if (clk_en)
        begin
            if (fall_ev)
            begin
                serial_data_out_pin <= sr_r[SIO3_WIDTH-1]; // [RULE_01] [RULE_07]
            end
            else if (state_r == SIO3_IDLE && trig.bus_release_trigger_flag)
            begin
                serial_data_out_pin <= 1'b1; // [RULE_07] [RULE_08]
            end
            else if (state_r == SIO3_IDLE && trig.command_trigger_flag)
            begin
                serial_data_out_pin <= 1'b0; // [RULE_07]
            end
        end
    end

    // completion status and request; a new completion beats the clear
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            serial_irq_request_flag <= 1'b0;
            cpu_irq_r <= 1'b0;
            irq_vector_r <= 8'h00;
            rx_data_r <= SIO3_SR_RST;
            rx_valid_r <= 1'b0;
            busy_r <= 1'b0;
        end
        else if (clk_en)
        begin
            busy_r <= (state_r == SIO3_SHIFT) || start;
            rx_valid_r <= done_ev;
            if (done_ev)
            begin
                rx_data_r <= {sr_r[SIO3_WIDTH-2:0], si_s2_r};
            end
            if (done_ev)
            begin
                serial_irq_request_flag <= 1'b1; // [RULE_05]
            end
            else if (irq_accept)
            begin
                serial_irq_request_flag <= 1'b0;
            end
            // request reaches the cpu only with both enables set
            cpu_irq_r <= (serial_irq_request_flag || done_ev) && serial_irq_permit_flag
                && global_interrupt_enable && !(irq_accept && !done_ev);
            if (irq_accept && cpu_irq_r)
            begin
                irq_vector_r <= SIO3_VECTOR; // [RULE_17]
            end
        end
    end
endmodule : sio3_top

// File: tb/sio3_props.sv
/*
 port checker for sio3_top, bound below.
 assumes nrst is the raw pin reset of the bound top.
*/
module sio3_props
    import sio3_pkg::*;
(
    // clock, reset, enable
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic clk_en,
    // controls
    input wire sio3_ctrl_t ctrl,
    input wire logic irq_accept,
    // status
    input wire logic [SIO3_WIDTH-1:0] rx_data_r,
    input wire logic rx_valid_r,
    input wire logic busy_r,
    input wire logic serial_irq_request_flag,
    input wire logic cpu_irq_r,
    input wire logic [7:0] irq_vector_r,
    // clock pin
    input wire logic serial_clock_pin_o,
    input wire logic serial_clock_pin_oe
);
    logic act;
    logic sck_r;
    logic busy_d_r;
    logic [3:0] rises_r;
    logic [3:0] tot;
    assign act = ctrl.serial_if_enable_flag & ~ctrl.mode_select_bit2 & ~ctrl.mode_select_bit1;
    // eighth rise may land in the same cycle as completion
    assign tot = rises_r + {3'h0, serial_clock_pin_o & ~sck_r};
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            sck_r <= 1'b1;
            busy_d_r <= 1'b0;
            rises_r <= 4'h0;
        end
        else
        begin
            sck_r <= serial_clock_pin_o;
            busy_d_r <= busy_r;
            // back-to-back frames keep busy high, so completion restarts the count
            if (rx_valid_r || (busy_r && !busy_d_r))
                rises_r <= 4'h0;
            else if (serial_clock_pin_oe && serial_clock_pin_o && !sck_r)
                rises_r <= rises_r + 4'h1;
        end
    end
    default clocking dcb @(posedge ref_clk);
    endclocking
    default disable iff (!nrst);
    chk_slave_hiz:
        assert property ((clk_en && !(act && ctrl.clock_source_select)) |=> !serial_clock_pin_oe)
        else $error("clock pin driven outside master mode");
    chk_master_drive:
        assert property ((clk_en && act && ctrl.clock_source_select) |=> serial_clock_pin_oe)
        else $error("master clock not driven");
    chk_idle_high:
        assert property ((!busy_r && serial_clock_pin_oe) |-> serial_clock_pin_o)
        else $error("master clock low while idle");
    chk_eight_pulses:
        assert property ((rx_valid_r && serial_clock_pin_oe) |-> tot == 4'h8)
        else $error("completion without eight clock rises");
    chk_flag_done:
        assert property (rx_valid_r |-> serial_irq_request_flag)
        else $error("request flag missing at completion");
    chk_flag_sticky:
        assert property ((serial_irq_request_flag && !irq_accept) |=> serial_irq_request_flag)
        else $error("request flag dropped without accept");
    chk_vector_load:
        assert property ((clk_en && irq_accept && cpu_irq_r) |=> irq_vector_r == SIO3_VECTOR)
        else $error("vector not loaded on accept");
    chk_rx_hold:
        assert property ($changed(rx_data_r) |-> rx_valid_r)
        else $error("received byte changed without completion");
endmodule : sio3_props

bind sio3_top sio3_props u_props (.ref_clk, .nrst, .clk_en, .ctrl, .irq_accept,
    .rx_data_r, .rx_valid_r, .busy_r, .serial_irq_request_flag, .cpu_irq_r,
    .irq_vector_r, .serial_clock_pin_o, .serial_clock_pin_oe);

// File: tb/sio3_peer.sv
/*
 far-side peer on the three-wire link, slave or master role.
 assumes the bench resolves the clock wire with a pull-up.
*/
module sio3_peer
(
    // link
    input wire logic sck,
    input wire logic sdo,
    output logic sck_o,
    output logic sck_oe,
    output logic sdi
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] tx_sr;
    logic [7:0] rx_sr;
    initial
    begin
        sck_o = 1'b1;
        sck_oe = 1'b0;
        sdi = 1'b0;
        tx_sr = 8'h00;
        rx_sr = 8'h00;
    end
    // rotate so a back-to-back frame resends the same byte
    always @(negedge sck)
    begin
        sdi <= tx_sr[7];
        tx_sr <= {tx_sr[6:0], tx_sr[7]};
    end
    always @(posedge sck)
        rx_sr <= {rx_sr[6:0], sdo};
    // master role: 160 ns clock only inside a frame
    task automatic frame();
        repeat (8)
        begin
            sck_oe = 1'b1;
            sck_o = 1'b0;
            #80;
            sck_o = 1'b1;
            #80;
        end
        sck_oe = 1'b0;
    endtask : frame
endmodule : sio3_peer

// File: tb/tb_top.sv
/*
 self-checking bench for sio3_top with a link peer.
 assumes the checker is bound and the peer model is compiled.
*/
module tb_top
    import sio3_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic ref_clk, nrst, clk_en, permit, gie, acc, tx_valid, tx_ready;
    logic rx_valid, busy, flag, cpu_irq, sck_o, sck_oe, sdo, p_o, p_oe, sdi;
    logic [7:0] tx_data, rx_data, vec;
    sio3_ctrl_t ctrl;
    sio3_trig_t trig;
    wire logic sck_w;
    int err_total, checks_done;
    assign sck_w = sck_oe ? sck_o : (p_oe ? p_o : 1'b1);
    sio3_top #(.SCK_HALF_CYC(4)) u_dut (.ref_clk(ref_clk), .nrst(nrst), .clk_en(clk_en),
        .ctrl(ctrl), .trig(trig), .serial_irq_permit_flag(permit),
        .global_interrupt_enable(gie), .irq_accept(acc), .tx_valid(tx_valid),
        .tx_ready(tx_ready), .tx_data(tx_data), .rx_data_r(rx_data), .rx_valid_r(rx_valid),
        .busy_r(busy), .serial_irq_request_flag(flag), .cpu_irq_r(cpu_irq),
        .irq_vector_r(vec), .serial_clock_pin_i(sck_w), .serial_clock_pin_o(sck_o),
        .serial_clock_pin_oe(sck_oe), .serial_data_in_pin(sdi), .serial_data_out_pin(sdo));
    sio3_peer u_peer (.sck(sck_w), .sdo(sdo), .sck_o(p_o), .sck_oe(p_oe), .sdi(sdi));
    always #10 ref_clk = ~ref_clk;
    task automatic stop_test();
        $display("errors %0d checks %0d", err_total, checks_done);
        if (err_total == 0 && checks_done > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : stop_test
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            err_total++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic tick(input int n);
        repeat (n) @(negedge ref_clk);
    endtask : tick
    task automatic hang(input int n);
        if (n > 3000)
        begin
            err_total++;
            stop_test();
        end
    endtask : hang
    task automatic wait_rx();
        int n;
        n = 0;
        while (rx_valid !== 1'b1)
        begin
            tick(1);
            n++;
            hang(n);
        end
    endtask : wait_rx
    task automatic push(input logic [7:0] b);
        int n;
        n = 0;
        tx_valid = 1'b1;
        tx_data = b;
        while (tx_ready !== 1'b1)
        begin
            tick(1);
            n++;
            hang(n);
        end
        tick(1);
        tx_valid = 1'b0;
        // idle cycle so back-to-back pushes never toggle valid in one step
        tick(1);
    endtask : push
    task automatic pulse(input logic [1:0] t);
        trig = sio3_trig_t'(t);
        tick(1);
        trig = sio3_trig_t'(2'b00);
        tick(1);
    endtask : pulse
    task automatic t_master();
        ctrl = sio3_ctrl_t'(4'h9);
        permit = 1'b1;
        gie = 1'b1;
        u_peer.tx_sr = 8'h3C;
        pulse(2'b01);
        chk(sdo, 0);
        chk(sck_oe, 1);
        push(8'hA5);
        push(8'h81);
        wait_rx();
        chk(rx_data, 8'h3C);
        chk(u_peer.rx_sr, 8'hA5);
        chk(flag, 1);
        tick(1);
        chk(cpu_irq, 1);
        acc = 1'b1;
        tick(1);
        acc = 1'b0;
        chk(vec, SIO3_VECTOR);
        chk(flag, 0);
        wait_rx();
        chk(u_peer.rx_sr, 8'h81);
        tick(2);
        chk(sck_o, 1);
    endtask : t_master
    task automatic t_trig();
        clk_en = 1'b0;
        pulse(2'b01);
        clk_en = 1'b1;
        chk(sdo, 1);
        pulse(2'b01);
        chk(sdo, 0);
        pulse(2'b10);
        chk(sdo, 1);
    endtask : t_trig
    task automatic t_refuse();
        logic hit;
        for (int m = 0; m < 4; m++)
        begin
            hit = 1'b0;
            ctrl = sio3_ctrl_t'({m != 0, m[1:0], 1'b1});
            tick(2);
            push(8'hC3);
            ctrl.serial_if_enable_flag = 1'b1;
            repeat (100)
            begin
                tick(1);
                hit = hit | (busy !== 1'b0);
            end
            chk(hit, 0);
        end
    endtask : t_refuse
    task automatic t_slave();
        int n;
        ctrl = sio3_ctrl_t'(4'h8);
        tick(2);
        chk(sck_oe, 0);
        n = 0;
        while (tx_ready === 1'b1 && n < 12)
        begin
            push(8'h40 + n[7:0]);
            n++;
        end
        chk(n[7:0], 8'h09);
        chk(busy, 1);
        for (int i = 0; i < 9; i++)
        begin
            u_peer.tx_sr = 8'hF0 ^ i[7:0];
            fork
                u_peer.frame();
                wait_rx();
            join
            chk(u_peer.rx_sr, 8'h40 + i[7:0]);
            chk(rx_data, 8'hF0 ^ i[7:0]);
            tick(2);
        end
    endtask : t_slave
    initial
    begin
        ref_clk = 1'b0;
        nrst = 1'b0;
        clk_en = 1'b1;
        permit = 1'b0;
        gie = 1'b0;
        acc = 1'b0;
        tx_valid = 1'b0;
        tx_data = 8'h00;
        ctrl = sio3_ctrl_t'(4'h0);
        trig = sio3_trig_t'(2'b00);
        err_total = 0;
        checks_done = 0;
        tick(4);
        nrst = 1'b1;
        tick(4);
        t_master();
        t_trig();
        t_refuse();
        t_slave();
        stop_test();
    end
endmodule : tb_top
